// ==== inc/sar_adc_pkg.sv ====
/*
 Constants, register map and types of the successive-approximation converter sequencer.
 Assumes one clock domain and a 32-bit AHB-Lite register bus, one word per register.
*/
package sar_adc_pkg;
   localparam logic [11:0] STAT_CTRL_OFS   = 12'h038;
   localparam logic [11:0] RESULT_OFS      = 12'h03c;
   localparam logic [11:0] CLK_DIV_OFS     = 12'h040;
   localparam logic [11:0] IRQ_STAT_OFS    = 12'h044;
   localparam logic [11:0] IRQ_EN_OFS      = 12'h048;
   localparam logic [11:0] IRQ_CLR_OFS     = 12'h04c;
   localparam logic [11:0] PORT_DATA_OFS   = 12'h050;
   localparam logic [11:0] PORT_DIR_OFS    = 12'h054;
   localparam logic [11:0] PORT_PINS_OFS   = 12'h058;
   localparam int          DONE_BIT        = 7;
   localparam int          IEN_BIT         = 6;
   localparam int          CONT_BIT        = 5;
   localparam logic [4:0]  CHAN_OFF        = 5'h1f;
   localparam logic [4:0]  CHAN_LAST       = 5'h0e;
   localparam logic [7:0]  CLK_DIV_RESET   = 8'h00;
   localparam int          CONV_TICKS      = 16;
   localparam int          RESULT_BITS     = 8;
   localparam int          NUM_CHANNELS    = 15;
   localparam int          IRQ_EOC_BIT     = 0;
   localparam int          IRQ_ABORT_BIT   = 1;
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_WAIT   = 2'b01,
      ST_SAMPLE = 2'b11,
      ST_DONE   = 2'b10
   } seq_state_type;
endpackage : sar_adc_pkg

// ==== rtl/sar_adc_sequencer.sv ====
/*
 Converter sequencer: AHB-Lite registers, channel mux and port pin takeover, timing, flags.
 Assumes an external comparator against a DAC of the trial code; full-scale mapping
 (FF at or above high reference, 00 at or below low) follows from the trial search.
*/
`timescale 1ns/1ps
module sar_adc_sequencer
   import sar_adc_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input  wire logic                i_mclk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_hsel,
   input  wire logic [31:0]         i_haddr,
   input  wire logic [1:0]          i_htrans,
   input  wire logic                i_hwrite,
   input  wire logic [2:0]          i_hsize,
   input  wire logic [31:0]         i_hwdata,
   input  wire logic                i_hready,
   output logic [31:0]              o_hrdata,
   output logic                     o_hreadyout,
   output logic                     o_hresp,
   input  wire logic                i_cmp_above,
   output logic [RESULT_BITS-1:0]   o_dac_code,
   output logic                     o_sample,
   output logic [CHANNELS-1:0]      o_mux_sel,
   output logic                     o_adc_power,
   input  wire logic                i_stop_mode,
   input  wire logic [CHANNELS-1:0] i_pin_in,
   output logic [CHANNELS-1:0]      o_pin_out,
   output logic [CHANNELS-1:0]      o_pin_oe,
   output logic                     o_irq
);
   initial begin
      if (CHANNELS != NUM_CHANNELS) $error("channel count must be fifteen");
   end

   seq_state_type                 state_q, state_d;
   logic [4:0]                    chan_q;
   logic                          cont_q, ien_q, done_q;
   logic [RESULT_BITS-1:0]        result_q;
   logic [7:0]                    div_q, div_cnt_q;
   logic [4:0]                    tick_cnt_q;
   logic                          pending_q;
   logic [1:0]                    istat_q, ien_mask_q;
   logic [CHANNELS-1:0]           pdata_q, pdir_q;
   logic                          adc_irq_q;
   logic                          ap_valid_q, ap_write_q;
   logic [11:0]                   ap_addr_q;
   logic [31:0]                   rdata_q;
   logic [RESULT_BITS-1:0]        trial;
   logic                          core_busy;

   // Address phase capture; data phase follows with zero wait states
   wire addr_ok     = i_hsel && i_htrans[1] && i_hready;
   wire wr_ctrl     = ap_valid_q && ap_write_q && ap_addr_q == STAT_CTRL_OFS;
   wire rd_result   = addr_ok && !i_hwrite && i_haddr[11:0] == RESULT_OFS;
   wire wr_div      = ap_valid_q && ap_write_q && ap_addr_q == CLK_DIV_OFS;
   wire wr_ien      = ap_valid_q && ap_write_q && ap_addr_q == IRQ_EN_OFS;
   wire wr_iclr     = ap_valid_q && ap_write_q && ap_addr_q == IRQ_CLR_OFS;
   wire wr_pdata    = ap_valid_q && ap_write_q && ap_addr_q == PORT_DATA_OFS;
   wire wr_pdir     = ap_valid_q && ap_write_q && ap_addr_q == PORT_DIR_OFS;
   wire powered     = chan_q != CHAN_OFF;
   wire chan_valid  = chan_q <= CHAN_LAST;
   wire tick        = (div_cnt_q == 8'h00) && !i_stop_mode;
   wire eoc         = (state_q == ST_SAMPLE) && tick && (tick_cnt_q == 5'(CONV_TICKS - 1));
   wire abort       = i_stop_mode && (state_q != ST_IDLE);
   wire core_start  = (state_q == ST_WAIT) && tick;
   wire [CHANNELS-1:0] sel_onehot = chan_valid ? CHANNELS'(1) << chan_q : '0;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ap_valid_q <= 1'b0;
         ap_write_q <= 1'b0;
         ap_addr_q  <= '0;
      end else begin
         ap_valid_q <= addr_ok;
         ap_write_q <= i_hwrite;
         ap_addr_q  <= i_haddr[11:0];
      end
   end

   // Read mux, registered during address phase so data stand in data phase
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (i_haddr[11:0])
         STAT_CTRL_OFS: rd_mux = {24'h0, done_q, ien_q, cont_q, chan_q};
         RESULT_OFS:    rd_mux = {24'h0, result_q};
         CLK_DIV_OFS:   rd_mux = {24'h0, div_q};
         IRQ_STAT_OFS:  rd_mux = {30'h0, istat_q};
         IRQ_EN_OFS:    rd_mux = {30'h0, ien_mask_q};
         PORT_DATA_OFS: rd_mux = {17'h0, pdata_q};
         PORT_DIR_OFS:  rd_mux = {17'h0, pdir_q};
         // Selected pin reads 0 when input, latch when output
         PORT_PINS_OFS: rd_mux = {17'h0, ((i_pin_in & ~pdir_q) | (pdata_q & pdir_q))
                                  & ~(sel_onehot & ~pdir_q)};
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) rdata_q <= '0;
      else if (addr_ok && !i_hwrite) rdata_q <= rd_mux;
   end

   // Control register and port latches
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         chan_q     <= CHAN_OFF;
         cont_q     <= 1'b0;
         ien_q      <= 1'b0;
         div_q      <= CLK_DIV_RESET;
         ien_mask_q <= '0;
         pdata_q    <= '0;
         pdir_q     <= '0;
      end else begin
         if (wr_ctrl) begin
            chan_q <= i_hwdata[4:0];
            cont_q <= i_hwdata[CONT_BIT];
            ien_q  <= i_hwdata[IEN_BIT];
         end
         if (wr_div) div_q <= i_hwdata[7:0];
         if (wr_ien) ien_mask_q <= i_hwdata[1:0];
         if (wr_pdata) pdata_q <= i_hwdata[CHANNELS-1:0];
         if (wr_pdir) pdir_q <= i_hwdata[CHANNELS-1:0];
      end
   end

   // Converter clock: one-cycle tick every div_q+1 bus cycles
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || div_cnt_q == 8'h00) div_cnt_q <= i_sys_rst ? 8'h00 : div_q;
      else div_cnt_q <= div_cnt_q - 8'h01;
   end

   // Sequence: wait for next tick, then sixteen ticks to result
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:   if (pending_q && powered) state_d = ST_WAIT;
         ST_WAIT:   if (tick) state_d = ST_SAMPLE;
         ST_SAMPLE: if (eoc) state_d = ST_DONE;
         ST_DONE:   state_d = cont_q ? ST_SAMPLE : ST_IDLE;
         default:   state_d = ST_IDLE;
      endcase
      // Control write while a channel is powered arms the wait for the next tick at once, no idle cycle
      if (wr_ctrl) state_d = ST_WAIT;
      // Stop parks the sequence; the pending start survives to resume it
      if (i_stop_mode || !powered) state_d = ST_IDLE;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state_q    <= ST_IDLE;
         tick_cnt_q <= '0;
         pending_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q != ST_SAMPLE) tick_cnt_q <= '0;
         else if (tick) tick_cnt_q <= tick_cnt_q + 5'd1;
         if (wr_ctrl) pending_q <= 1'b1;
         else if (state_q == ST_DONE && !cont_q) pending_q <= 1'b0;
      end
   end

   // Result, done flag and interrupt; set wins over clear
   wire flag_clr = wr_ctrl || rd_result;
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         result_q  <= '0;
         done_q    <= 1'b0;
         adc_irq_q <= 1'b0;
         istat_q   <= '0;
      end else begin
         if (eoc) result_q <= {trial[RESULT_BITS-1:1], i_cmp_above};
         if (eoc && !ien_q) done_q <= 1'b1;
         else if (flag_clr) done_q <= 1'b0;
         if (eoc && ien_q) adc_irq_q <= 1'b1;
         else if (flag_clr) adc_irq_q <= 1'b0;
         istat_q[IRQ_EOC_BIT] <= eoc || (istat_q[IRQ_EOC_BIT]
                                 && !(wr_iclr && i_hwdata[IRQ_EOC_BIT]));
         istat_q[IRQ_ABORT_BIT] <= abort || (istat_q[IRQ_ABORT_BIT]
                                   && !(wr_iclr && i_hwdata[IRQ_ABORT_BIT]));
      end
   end

   // Search runs in the first seven ticks; last bit decided and result latched at tick sixteen
   sar_core #(
      .WIDTH       (RESULT_BITS)
   ) u_core (
      .i_mclk      (i_mclk),
      .i_sys_rst   (i_sys_rst),
      .i_tick      (tick && state_q == ST_SAMPLE && tick_cnt_q < 5'(RESULT_BITS - 1)),
      .i_start     (core_start || (state_q == ST_DONE && cont_q)),
      .i_abort     (abort || wr_ctrl),
      .i_cmp_above (i_cmp_above),
      .o_trial     (trial),
      .o_busy      (core_busy)
   );

   // Pin takeover: selected pin released from port latches one cycle after it is selected
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_pin_out <= '0;
         o_pin_oe  <= '0;
      end else begin
         o_pin_out <= pdata_q & ~sel_onehot;
         o_pin_oe  <= pdir_q & ~sel_onehot;
      end
   end

   assign o_mux_sel   = sel_onehot;
   assign o_dac_code  = trial;
   assign o_sample    = state_q == ST_SAMPLE && core_busy;
   assign o_adc_power = powered;
   assign o_hrdata    = rdata_q;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_irq       = adc_irq_q || |(istat_q & ien_mask_q);
endmodule : sar_adc_sequencer

// ==== rtl/sar_core.sv ====
/*
 Successive-approximation bit search: one bit per enabled tick, MSB first.
 Assumes a comparator answering in the tick after the trial code is shown.
*/
`timescale 1ns/1ps
module sar_core
   import sar_adc_pkg::*;
#(
   parameter int WIDTH = RESULT_BITS
) (
   input  wire logic             i_mclk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_tick,
   input  wire logic             i_start,
   input  wire logic             i_abort,
   input  wire logic             i_cmp_above,
   output logic [WIDTH-1:0]      o_trial,
   output logic                  o_busy
);
   initial begin
      if (WIDTH < 2 || WIDTH > 16) $error("sar_core width unsupported");
   end

   logic [WIDTH-1:0] trial_q;
   logic [WIDTH-1:0] mask_q;
   logic             busy_q;

   // Keep a tested bit when input is above trial, then try next lower bit
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst || i_abort) begin
         trial_q <= '0;
         mask_q  <= '0;
         busy_q  <= 1'b0;
      end else if (i_start) begin
         trial_q <= {1'b1, {(WIDTH-1){1'b0}}};
         mask_q  <= {1'b1, {(WIDTH-1){1'b0}}};
         busy_q  <= 1'b1;
      end else if (i_tick && busy_q) begin
         trial_q <= (i_cmp_above ? trial_q : (trial_q & ~mask_q)) | (mask_q >> 1);
         mask_q  <= mask_q >> 1;
         busy_q  <= (mask_q != {{(WIDTH-1){1'b0}}, 1'b1});
      end
   end

   assign o_trial = trial_q;
   assign o_busy  = busy_q;
endmodule : sar_core

// ==== tb/sar_adc_sequencer_props.sv ====
/*
 Port checker for the converter sequencer.
 Assumes one clock, synchronous active-high reset, bound to the top module.
*/
`timescale 1ns/1ps
module sar_adc_props
   import sar_adc_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input  wire logic                i_mclk,
   input  wire logic                i_sys_rst,
   input  wire logic                i_hsel,
   input  wire logic [31:0]         i_haddr,
   input  wire logic [1:0]          i_htrans,
   input  wire logic                i_hwrite,
   input  wire logic                i_hready,
   input  wire logic                i_stop_mode,
   input  wire logic [31:0]         o_hrdata,
   input  wire logic                o_hreadyout,
   input  wire logic                o_hresp,
   input  wire logic                o_sample,
   input  wire logic [CHANNELS-1:0] o_mux_sel,
   input  wire logic                o_adc_power,
   input  wire logic [CHANNELS-1:0] o_pin_oe,
   input  wire logic                o_irq
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   // Address phase of a read to a hole in the map
   sequence rd_hole;
      i_hsel && i_htrans[1] && i_hready && !i_hwrite && i_haddr[11:0] == 12'hffc;
   endsequence
   sequence stop_entry;
      $rose(i_stop_mode);
   endsequence
   a_hole_reads_zero: assert property (rd_hole |=> o_hrdata == 32'h0)
      else $error("hole read not zero");
   a_stop_aborts: assert property (stop_entry |-> ##[1:2] !o_sample)
      else $error("sampling kept in stop");
   a_stop_stays_idle: assert property (i_stop_mode && $past(i_stop_mode) |-> !o_sample)
      else $error("sampling during stop");
   a_bus_zero_wait: assert property (o_hreadyout && !o_hresp)
      else $error("wait state or error response");
   a_mux_one_hot: assert property ($onehot0(o_mux_sel))
      else $error("more than one channel routed");
   a_power_off_mux: assert property (!o_adc_power |-> o_mux_sel == '0)
      else $error("channel routed while powered down");
   a_sel_pin_free: assert property ((o_mux_sel & o_pin_oe) == '0)
      else $error("selected pin driven by port");
   a_reset_idle: assert property ($fell(i_sys_rst) |-> !o_adc_power && !o_irq && !o_sample)
      else $error("not idle after reset");
endmodule : sar_adc_props
bind sar_adc_sequencer sar_adc_props #(.CHANNELS(CHANNELS)) i_props (
   .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
   .i_stop_mode(i_stop_mode), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
   .o_hresp(o_hresp), .o_sample(o_sample), .o_mux_sel(o_mux_sel),
   .o_adc_power(o_adc_power), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

// ==== tb/sar_adc_sequencer_test.sv ====
/*
 Self-checking bench of the converter sequencer.
 Assumes the analog model at the far side and AHB-Lite tasks as master.
*/
`timescale 1ns/1ps
module sar_adc_sequencer_test;
   import sar_adc_pkg::*;
   logic        i_mclk = 0, i_sys_rst = 1, i_hsel = 0, i_hwrite = 0, i_stop_mode = 0;
   logic [31:0] i_haddr = 0, i_hwdata = 0, rd, o_hrdata;
   logic [1:0]  i_htrans = 0;
   logic        o_hreadyout, o_hresp, cmp, o_sample, o_adc_power, o_irq;
   logic [7:0]  dac;
   logic [14:0] mux, pin_in, pin_out, pin_oe;
   int          error_cnt = 0, samples_checked = 0, cyc = 0;
   always #2 i_mclk = ~i_mclk;
   always @(posedge i_mclk) cyc <= cyc + 1;
   sar_adc_sequencer i_sar_adc_sequencer (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
      .i_hsize(3'h2), .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata),
      .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_cmp_above(cmp), .o_dac_code(dac),
      .o_sample(o_sample), .o_mux_sel(mux), .o_adc_power(o_adc_power),
      .i_stop_mode(i_stop_mode), .i_pin_in(pin_in), .o_pin_out(pin_out),
      .o_pin_oe(pin_oe), .o_irq(o_irq));
   sar_analog_model i_model (.i_mclk(i_mclk), .i_mux_sel(mux), .i_dac_code(dac),
      .i_pin_out(pin_out), .i_pin_oe(pin_oe), .o_cmp_above(cmp), .o_pin_in(pin_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      i_hsel <= 1; i_htrans <= 2'h2; i_hwrite <= w; i_haddr <= {20'h0, a};
      do @(posedge i_mclk); while (!o_hreadyout);
      i_hsel <= 0; i_htrans <= 2'h0; i_hwdata <= d;
      do @(posedge i_mclk); while (!o_hreadyout);
      rd = o_hrdata;
   endtask : xfer
   task automatic t_conv(input int ch, input logic [7:0] lvl, input int dv);
      int t0;
      i_model.level[ch] = lvl;
      xfer(1, CLK_DIV_OFS, dv);
      xfer(1, STAT_CTRL_OFS, ch);
      t0 = cyc;
      do xfer(0, STAT_CTRL_OFS, 0); while (!rd[DONE_BIT] && cyc - t0 < 300);
      chk(32'(cyc - t0 >= 16 * (dv + 1) && cyc - t0 <= 17 * (dv + 1) + 4), 1);
      xfer(0, RESULT_OFS, 0);
      chk(rd, lvl);
      repeat (40 * (dv + 1)) @(posedge i_mclk);
      xfer(0, STAT_CTRL_OFS, 0);
      chk(rd, ch);
   endtask : t_conv
   task automatic t_pins;
      xfer(1, STAT_CTRL_OFS, 3);
      xfer(1, PORT_DIR_OFS, 32'h7fff);
      xfer(1, PORT_DATA_OFS, 32'h7fff);
      repeat (2) @(posedge i_mclk);
      chk(pin_oe, 32'h7ff7);
      chk(pin_out, 32'h7ff7);
      xfer(0, PORT_PINS_OFS, 0);
      chk(rd, 32'h7fff);
      xfer(1, PORT_DIR_OFS, 0);
      xfer(0, PORT_PINS_OFS, 0);
      chk(rd, 32'h7ff7);
   endtask : t_pins
   task automatic wait_irq;
      for (int n = 0; n < 60 && !o_irq; n++) @(posedge i_mclk);
      chk(o_irq, 1);
   endtask : wait_irq
   task automatic t_cont;
      i_model.level[2] = 8'h11;
      xfer(1, STAT_CTRL_OFS, 32'h62);
      wait_irq;
      xfer(0, RESULT_OFS, 0);
      chk(rd, 32'h11);
      i_model.level[2] = 8'h22;
      repeat (50) @(posedge i_mclk);
      xfer(0, RESULT_OFS, 0);
      chk(rd, 32'h22);
      xfer(1, STAT_CTRL_OFS, 32'h42);
      wait_irq;
      xfer(0, RESULT_OFS, 0);
      repeat (60) @(posedge i_mclk);
      chk(o_irq, 0);
   endtask : t_cont
   task automatic t_irq;
      xfer(0, IRQ_STAT_OFS, 0);
      chk(rd[IRQ_EOC_BIT], 1);
      chk(o_irq, 0);
      xfer(1, IRQ_EN_OFS, 1);
      repeat (2) @(posedge i_mclk);
      chk(o_irq, 1);
      xfer(1, IRQ_CLR_OFS, 1);
      repeat (2) @(posedge i_mclk);
      chk(o_irq, 0);
      xfer(1, IRQ_EN_OFS, 0);
   endtask : t_irq
   task automatic t_stop;
      xfer(1, STAT_CTRL_OFS, 5);
      repeat (6) @(posedge i_mclk);
      i_stop_mode <= 1;
      repeat (30) @(posedge i_mclk);
      xfer(0, STAT_CTRL_OFS, 0);
      chk(rd, 5);
      i_stop_mode <= 0;
      repeat (40) @(posedge i_mclk);
      xfer(0, STAT_CTRL_OFS, 0);
      chk(rd, 32'h85);
      xfer(0, RESULT_OFS, 0);
      chk(rd, 32'h55);
   endtask : t_stop
   task end_of_test;
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   // Main sequence; channel 14 used with no timer clock on its pin
   initial begin
      repeat (5) @(posedge i_mclk);
      i_sys_rst <= 0;
      @(posedge i_mclk);
      xfer(0, STAT_CTRL_OFS, 0);
      chk(rd, 32'h1f);
      xfer(0, 12'hffc, 0);
      chk(rd, 0);
      for (int c = 0; c < 15; c++) t_conv(c, (c == 14) ? 8'hff : 8'(c * 17), 0);
      t_pins;
      t_cont;
      t_irq;
      t_stop;
      t_conv(9, 8'h5a, 1);
      end_of_test;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge i_mclk);
      error_cnt++;
      end_of_test;
   end
endmodule : sar_adc_sequencer_test

// ==== tb/sar_analog_model.sv ====
/*
 Analog side: per-channel levels, comparator and shared port pins.
 Assumes a one-hot mux select and the trial code of the sequencer.
*/
`timescale 1ns/1ps
module sar_analog_model (
   input  wire logic        i_mclk,
   input  wire logic [14:0] i_mux_sel,
   input  wire logic [7:0]  i_dac_code,
   input  wire logic [14:0] i_pin_out,
   input  wire logic [14:0] i_pin_oe,
   output logic             o_cmp_above,
   output logic [14:0]      o_pin_in
);
   logic [7:0]  level [15] = '{default: 8'h00};
   logic [14:0] ext = 15'h7fff;
   logic        tgl = 1'b0;
   logic [7:0]  vin;
   // Unselected comparator answers with noise
   always_ff @(posedge i_mclk) tgl <= ~tgl;
   // Route the one selected channel
   always_comb begin
      vin = 8'h00;
      for (int c = 0; c < 15; c++) if (i_mux_sel[c]) vin = level[c];
   end
   // Input sits half a step above its level
   assign o_cmp_above = (i_mux_sel == '0) ? tgl : (vin >= i_dac_code);
   assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext);
endmodule : sar_analog_model
